/* File: hdl/pmc_defines.svh */
// register indexes, field positions, reset values and timing constants
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH
`define PMC_IDX_IND_CFG 16'h0469
`define PMC_IDX_POL_CFG 16'h0475
`define PMC_IDX_MON_PER 16'h0480
`define PMC_IDX_MON_RUN 16'h0481
`define PMC_IDX_STATUS 16'h048F
`define PMC_BIT_POL2 10
`define PMC_BIT_VAL2 9
`define PMC_BIT_EN2 8
`define PMC_BIT_POL1 6
`define PMC_BIT_VAL1 5
`define PMC_BIT_EN1 4
`define PMC_BIT_POL0 2
`define PMC_BIT_VAL0 1
`define PMC_BIT_EN0 0
`define PMC_BIT_FPOL_VAL 13
`define PMC_BIT_FPOL_EN 12
`define PMC_BIT_PERIODIC 1
`define PMC_BIT_START 0
`define PMC_RST_POL_CFG 16'h0000
`define PMC_RST_PERIOD 4'h2
`define PMC_RST_RUN_CFG 16'h00A2
`define PMC_STEP_NS 16000000
`define PMC_CLK_NS 5
`endif

/* File: hdl/pmc_pkg.sv */
// types shared by the misc configuration register block
package pmc_pkg;
  typedef enum logic {MON_IDLE, MON_PERIODIC} pmc_mon_st_t;
  typedef logic [2:0] pmc_ind_vec_t;
endpackage

/* File: hdl/pmc_regs.sv */
// indicator, line polarity and monitor scheduling registers on classic wishbone
// Behaviour
// - bits 10,6,2 set polarity of indicators 2,1,0; one is active high.
// - indicator 1 and 0 polarity reset from straps; indicator 2 polarity resets zero.
// - bits 9,5,1 give forced level of each indicator; reset zero.
// - bits 8,4,0 enable forcing each indicator to its override value; reset zero.
// - bit 13 of polarity register holds forced line polarity, one reversed, reset zero.
// - bit 12 set applies bit 13 polarity to the line instead of auto detection.
// - bit 12 clear (reset) keeps automatic receive polarity correction on the line.
// - period field 3:0 counts 16 ms steps, 16 to 240 ms, reset 0010.
// - period field only times sampling in periodic operation.
// - periodic bit 1 set (reset) runs monitors repeatedly at the period.
// - periodic bit clear runs monitors once per start request made while no periodic schedule is running.
// - writing one to start bit 0 launches monitors unless the same write stops a running schedule; bit self-clears; reset zero.
`timescale 1ns/1ps
`include "pmc_defines.svh"
module pmc_regs
  import pmc_pkg::*;
#(
  parameter int unsigned STEP_NS = `PMC_STEP_NS,
  parameter int unsigned CNT_W = 22
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic strap_pol_one_i,
  input wire logic strap_pol_zero_i,
  input wire logic [2:0] led_act_i,
  input wire logic auto_pol_rev_i,
  output logic indicator_out_zero_o,
  output logic indicator_out_one_o,
  output logic indicator_out_two_o,
  output logic mdi_pol_rev_o,
  output logic auto_pol_en_o,
  output logic mon_run_o
);
  localparam int unsigned STEP_CYC_I = (STEP_NS / `PMC_CLK_NS) < 1 ? 1 : STEP_NS / `PMC_CLK_NS;
  localparam logic [CNT_W-1:0] STEP_LAST = CNT_W'(STEP_CYC_I - 1);

  pmc_ind_vec_t ind_pol_r;
  pmc_ind_vec_t ind_val_r;
  pmc_ind_vec_t ind_en_r;
  pmc_ind_vec_t ind_out_r;
  logic [15:0] pol_cfg_r;
  logic [3:0] period_r;
  logic [15:0] run_cfg_r;
  logic start_r;
  logic [1:0] strap_s1_r;
  logic [1:0] strap_s2_r;
  logic strap_done_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic mdi_r;
  logic auto_en_r;
  logic run_r;
  pmc_mon_st_t mon_st_r;
  logic [CNT_W-1:0] tick_cnt_r;
  logic [3:0] step_cnt_r;
  logic acc;
  logic wr;
  logic [15:0] idx;
  logic step_tick;
  logic period_hit;

  assign acc = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr = acc && wb_we_i;
  // byte address is four times the register index
  assign idx = {2'b00, wb_adr_i[15:2]};
  assign step_tick = (tick_cnt_r == STEP_LAST);
  assign period_hit = step_tick && ((step_cnt_r + 4'h1) >= period_r);

  // strap pins are asynchronous: two flops before anything looks at them
  always_ff @(posedge clk_i)
  begin
    strap_s1_r <= {strap_pol_one_i, strap_pol_zero_i};
    strap_s2_r <= strap_s1_r;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= acc;
      if (acc && !wb_we_i)
      begin
        case (idx)
          `PMC_IDX_IND_CFG: dat_r <= {21'h000000, ind_pol_r[2], ind_val_r[2], ind_en_r[2], 1'b0,
            ind_pol_r[1], ind_val_r[1], ind_en_r[1], 1'b0, ind_pol_r[0], ind_val_r[0], ind_en_r[0]};
          `PMC_IDX_POL_CFG: dat_r <= {16'h0000, pol_cfg_r};
          `PMC_IDX_MON_PER: dat_r <= {28'h0000000, period_r};
          `PMC_IDX_MON_RUN: dat_r <= {16'h0000, run_cfg_r[15:1], start_r};
          `PMC_IDX_STATUS: dat_r <= {29'h00000000, auto_en_r, mdi_r, mon_st_r == MON_PERIODIC};
          default: dat_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // indicator register; straps are caught on the first edge after reset release
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ind_pol_r <= 3'h0;
      ind_val_r <= 3'h0;
      ind_en_r <= 3'h0;
      strap_done_r <= 1'b0;
    end
    else
    begin
      if (!strap_done_r)
      begin
        strap_done_r <= 1'b1;
        ind_pol_r[1:0] <= strap_s2_r;
      end
      else if (wr && wb_sel_i[1] && idx == `PMC_IDX_IND_CFG)
      begin
        ind_pol_r[2] <= wb_dat_i[`PMC_BIT_POL2];
        ind_val_r[2] <= wb_dat_i[`PMC_BIT_VAL2];
        ind_en_r[2] <= wb_dat_i[`PMC_BIT_EN2];
      end
      if (strap_done_r && wr && wb_sel_i[0] && idx == `PMC_IDX_IND_CFG)
      begin
        ind_pol_r[1] <= wb_dat_i[`PMC_BIT_POL1];
        ind_val_r[1] <= wb_dat_i[`PMC_BIT_VAL1];
        ind_en_r[1] <= wb_dat_i[`PMC_BIT_EN1];
        ind_pol_r[0] <= wb_dat_i[`PMC_BIT_POL0];
        ind_val_r[0] <= wb_dat_i[`PMC_BIT_VAL0];
        ind_en_r[0] <= wb_dat_i[`PMC_BIT_EN0];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_ind
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          ind_out_r[g] <= 1'b0;
        else if (ind_en_r[g])
          ind_out_r[g] <= ind_val_r[g];
        else
          ind_out_r[g] <= ind_pol_r[g] ? led_act_i[g] : !led_act_i[g];
      end
      chk_ind_force: assert property (@(posedge clk_i) disable iff (rst_i)
        ind_en_r[g] |=> ind_out_r[g] == $past(ind_val_r[g]))
        else $error("indicator override level not applied");
      // sampled reset keeps the release edge out: the pin still holds its reset level there
      chk_ind_polarity: assert property (@(posedge clk_i) disable iff (rst_i)
        !rst_i && !ind_en_r[g]
          |=> ind_out_r[g] == ($past(led_act_i[g]) ~^ $past(ind_pol_r[g])))
        else $error("indicator polarity not applied");
    end
  endgenerate

  // reserved bits of the polarity register are plain storage
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pol_cfg_r <= `PMC_RST_POL_CFG;
    else if (wr && idx == `PMC_IDX_POL_CFG)
    begin
      if (wb_sel_i[0])
        pol_cfg_r[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1])
        pol_cfg_r[15:8] <= wb_dat_i[15:8];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mdi_r <= 1'b0;
      auto_en_r <= 1'b1;
    end
    else
    begin
      auto_en_r <= !pol_cfg_r[`PMC_BIT_FPOL_EN];
      mdi_r <= pol_cfg_r[`PMC_BIT_FPOL_EN] ? pol_cfg_r[`PMC_BIT_FPOL_VAL] : auto_pol_rev_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      period_r <= `PMC_RST_PERIOD;
    else if (wr && wb_sel_i[0] && idx == `PMC_IDX_MON_PER)
      period_r <= wb_dat_i[3:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      run_cfg_r <= `PMC_RST_RUN_CFG;
      start_r <= 1'b0;
    end
    else
    begin
      if (wr && idx == `PMC_IDX_MON_RUN)
      begin
        if (wb_sel_i[0])
          run_cfg_r[7:1] <= wb_dat_i[7:1];
        if (wb_sel_i[1])
          run_cfg_r[15:8] <= wb_dat_i[15:8];
      end
      // a fresh write of one wins over the self clear; a zero does nothing
      start_r <= wr && wb_sel_i[0] && idx == `PMC_IDX_MON_RUN && wb_dat_i[`PMC_BIT_START];
    end
  end

  // the period only matters while runs repeat; a code of zero never fires early
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mon_st_r <= MON_IDLE;
      tick_cnt_r <= '0;
      step_cnt_r <= 4'h0;
      run_r <= 1'b0;
    end
    else
    begin
      run_r <= 1'b0;
      case (mon_st_r)
        MON_IDLE:
        begin
          tick_cnt_r <= '0;
          step_cnt_r <= 4'h0;
          if (start_r)
          begin
            run_r <= 1'b1;
            if (run_cfg_r[`PMC_BIT_PERIODIC])
              mon_st_r <= MON_PERIODIC;
          end
        end
        MON_PERIODIC:
        begin
          if (!run_cfg_r[`PMC_BIT_PERIODIC])
            mon_st_r <= MON_IDLE;
          else if (start_r)
          begin
            run_r <= 1'b1;
            tick_cnt_r <= '0;
            step_cnt_r <= 4'h0;
          end
          else if (step_tick)
          begin
            tick_cnt_r <= '0;
            if (period_hit)
            begin
              run_r <= 1'b1;
              step_cnt_r <= 4'h0;
            end
            else
              step_cnt_r <= step_cnt_r + 4'h1;
          end
          else
            tick_cnt_r <= tick_cnt_r + CNT_W'(1);
        end
        default: mon_st_r <= MON_IDLE;
      endcase
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign indicator_out_zero_o = ind_out_r[0];
  assign indicator_out_one_o = ind_out_r[1];
  assign indicator_out_two_o = ind_out_r[2];
  assign mdi_pol_rev_o = mdi_r;
  assign auto_pol_en_o = auto_en_r;
  assign mon_run_o = run_r;

  chk_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_pol2_reset: assert property (@(posedge clk_i)
    rst_i ##1 !rst_i |-> !ind_pol_r[2] && !ind_en_r[2])
    else $error("indicator two config not reset to zero");
  chk_force_line: assert property (@(posedge clk_i) disable iff (rst_i)
    pol_cfg_r[`PMC_BIT_FPOL_EN] |=> mdi_pol_rev_o == $past(pol_cfg_r[`PMC_BIT_FPOL_VAL])
      && !auto_pol_en_o)
    else $error("forced line polarity not applied");
  chk_auto_line: assert property (@(posedge clk_i) disable iff (rst_i)
    !pol_cfg_r[`PMC_BIT_FPOL_EN] |=> mdi_pol_rev_o == $past(auto_pol_rev_i) && auto_pol_en_o)
    else $error("automatic polarity not passed through");
  chk_start_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    start_r && !wr |=> !start_r)
    else $error("start bit did not self clear");
  chk_start_launch: assert property (@(posedge clk_i) disable iff (rst_i)
    start_r |=> mon_run_o)
    else $error("start did not launch a monitor run");
  chk_single_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    mon_st_r == MON_IDLE && !start_r |=> !mon_run_o)
    else $error("monitor ran without request in single mode");
  chk_period_fire: assert property (@(posedge clk_i) disable iff (rst_i)
    mon_st_r == MON_PERIODIC && run_cfg_r[`PMC_BIT_PERIODIC] && !start_r && period_hit
      |=> mon_run_o ##1 !mon_run_o)
    else $error("periodic run missing at period end");
  chk_zero_start: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && idx == `PMC_IDX_MON_RUN && !wb_dat_i[`PMC_BIT_START] |=> !start_r)
    else $error("writing zero to start had an effect");
  cov_single_run: cover property (@(posedge clk_i) disable iff (rst_i)
    start_r && !run_cfg_r[`PMC_BIT_PERIODIC] ##1 mon_run_o);
  cov_periodic_run: cover property (@(posedge clk_i) disable iff (rst_i)
    mon_st_r == MON_PERIODIC && period_hit ##1 mon_run_o);
  cov_force_led: cover property (@(posedge clk_i) disable iff (rst_i)
    ind_en_r[0] && ind_val_r[0] ##1 indicator_out_zero_o);
  cov_force_line: cover property (@(posedge clk_i) disable iff (rst_i)
    pol_cfg_r[`PMC_BIT_FPOL_EN] && pol_cfg_r[`PMC_BIT_FPOL_VAL] ##1 mdi_pol_rev_o);
endmodule

/* File: testbench/tb_top.sv */
// self-checking bench for the misc configuration register block
`timescale 1ns/1ps
`include "pmc_defines.svh"
module tb_top
  import pmc_pkg::*;
;
  logic clk_i, rst_i, cyc, stb, we, ack, s1, s0, apol, o0, o1, o2, mdi, apen, run;
  logic [15:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_w, dat_r;
  logic [2:0] act;
  logic [15:0] q;
  int n_errors, comparisons, pulses, g;
  logic [15:0] ind_tab [6] = '{16'h0444, 16'h0000, 16'h0333, 16'h0111, 16'h0262, 16'hFFFF};
  logic [15:0] pol_tab [4] = '{16'h3000, 16'h1000, 16'h2000, 16'hC00F};
  logic [3:0] code_tab [3] = '{4'h1, 4'h3, 4'hF};
  pmc_regs #(.STEP_NS(50), .CNT_W(22)) u_pmc_regs (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .strap_pol_one_i(s1),
    .strap_pol_zero_i(s0), .led_act_i(act), .auto_pol_rev_i(apol),
    .indicator_out_zero_o(o0), .indicator_out_one_o(o1), .indicator_out_two_o(o2),
    .mdi_pol_rev_o(mdi), .auto_pol_en_o(apen), .mon_run_o(run));
  initial
  begin
    clk_i = 0;
    forever #2.5 clk_i = ~clk_i;
  end
  // monitor requests counted in the background so reads can overlap them
  always @(posedge clk_i)
    if (run === 1'h1) pulses++;
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask
  // classic single cycle; ack is sampled before the edge's own updates land
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [15:0] d);
    int i;
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= {idx[13:0], 2'h0};
    sel <= 4'h3;
    dat_w <= {16'h0000, d};
    i = 0;
    do
    begin
      @(posedge clk_i);
      i++;
    end
    while (ack !== 1'h1 && i < 50);
    check("wb_ack", 16'h0001, {15'h0000, ack});
    q = dat_r[15:0];
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
  endtask
  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    xfer(1'h1, idx, d);
  endtask
  task automatic rd(input logic [15:0] idx, input logic [15:0] exp);
    xfer(1'h0, idx, 16'h0000);
    check("read_data", exp, q);
  endtask
  // counts edges until a request pulse is seen, bounded so a silent block cannot hang
  task automatic wait_pulse(output int n);
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (run !== 1'h1 && n < 400);
  endtask
  task automatic settle();
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  function automatic logic [2:0] ind_exp(logic [15:0] c, logic [2:0] a);
    logic [2:0] r;
    for (int i = 0; i < 3; i++)
      r[i] = c[4*i] ? c[4*i+1] : (c[4*i+2] ? a[i] : ~a[i]);
    return r;
  endfunction
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    finish_test();
  end
  initial
  begin
    rst_i = 1'h1;
    {cyc, stb, we, adr, sel, dat_w} = '0;
    s1 = 1'h1;
    s0 = 1'h0;
    act = 3'h0;
    apol = 1'h0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'h0;
    settle();
    check("auto_pol_en", 16'h0001, {15'h0000, apen});
    check("mdi_pol", 16'h0000, {15'h0000, mdi});
    check("indicators", {13'h0000, ind_exp(16'h0040, 3'h0)}, {13'h0000, o2, o1, o0});
    rd(`PMC_IDX_IND_CFG, 16'h0040);
    rd(`PMC_IDX_POL_CFG, 16'h0000);
    rd(`PMC_IDX_MON_PER, 16'h0002);
    rd(`PMC_IDX_MON_RUN, 16'h00A2);
    rd(`PMC_IDX_STATUS, 16'h0004);
    foreach (ind_tab[k])
    begin
      wr(`PMC_IDX_IND_CFG, ind_tab[k]);
      rd(`PMC_IDX_IND_CFG, ind_tab[k] & 16'h0777);
      for (int a = 0; a < 2; a++)
      begin
        act <= a ? 3'h2 : 3'h5;
        settle();
        check("indicators", {13'h0000, ind_exp(ind_tab[k], act)}, {13'h0000, o2, o1, o0});
      end
    end
    foreach (pol_tab[k])
    begin
      wr(`PMC_IDX_POL_CFG, pol_tab[k]);
      rd(`PMC_IDX_POL_CFG, pol_tab[k]);
      for (int a = 0; a < 2; a++)
      begin
        apol <= a[0];
        settle();
        check("mdi_pol", {15'h0000, pol_tab[k][12] ? pol_tab[k][13] : apol}, {15'h0000, mdi});
        check("auto_pol_en", {15'h0000, ~pol_tab[k][12]}, {15'h0000, apen});
      end
    end
    wr(`PMC_IDX_MON_PER, 16'hFFFF);
    rd(`PMC_IDX_MON_PER, 16'h000F);
    wr(16'h0470, 16'hFFFF);
    rd(16'h0470, 16'h0000);
    // single run with the shortest period: a periodic slip would show many pulses
    wr(`PMC_IDX_MON_PER, 16'h0001);
    g = pulses;
    wr(`PMC_IDX_MON_RUN, 16'h0001);
    rd(`PMC_IDX_MON_RUN, 16'h0000);
    repeat (100) @(posedge clk_i);
    check("mon_runs", 16'h0001, 16'(pulses - g));
    g = pulses;
    wr(`PMC_IDX_MON_RUN, 16'h0000);
    repeat (100) @(posedge clk_i);
    check("mon_runs", 16'h0000, 16'(pulses - g));
    foreach (code_tab[k])
    begin
      wr(`PMC_IDX_MON_PER, {12'h000, code_tab[k]});
      wr(`PMC_IDX_MON_RUN, 16'h0003);
      wait_pulse(g);
      check("start_delay", 16'h0001, 16'(g));
      repeat (2)
      begin
        wait_pulse(g);
        check("mon_period", {12'h000, code_tab[k]} * 16'h000A, 16'(g));
      end
      // schedule active, line follows the auto input (last set high), auto correction on
      rd(`PMC_IDX_STATUS, 16'h0007);
      wr(`PMC_IDX_MON_RUN, 16'h0000);
      repeat (2) @(posedge clk_i);
      g = pulses;
      repeat (200) @(posedge clk_i);
      check("mon_runs", 16'h0000, 16'(pulses - g));
      rd(`PMC_IDX_STATUS, 16'h0006);
    end
    finish_test();
  end
endmodule
